// ---- verilog/ldi_pkg.sv ----
// Constants of the LED driver interrupt unit: register addresses, field
// positions, reset values and the auto-clear timing.
// Assumes a 25 MHz core clock; the serial slave supplies byte accesses.
`default_nettype none

package ldi_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLES = 8'hf0;    // Interrupt enables, write only
    localparam logic [7:0] ADDR_FLAGS   = 8'hf1;    // Interrupt flags, read only

    // ------------------------------------------------------------------
    // Enable register fields
    // ------------------------------------------------------------------
    localparam int EN_WIDTH          = 4;           // Bits 7..4 unused
    localparam int EN_OPEN_BIT       = 0;           // Open dot source
    localparam int EN_SHORT_BIT      = 1;           // Short dot source
    localparam int EN_BREATH_BIT     = 2;           // Breath loop source
    localparam int EN_AUTO_CLEAR_BIT = 3;           // Pin auto release
    localparam logic [3:0] EN_RESET = 4'h0;         // All sources off

    // ------------------------------------------------------------------
    // Flag register fields
    // ------------------------------------------------------------------
    localparam int FL_WIDTH          = 5;           // Bits 7..5 unused
    localparam int FL_OPEN_BIT       = 0;
    localparam int FL_SHORT_BIT      = 1;
    localparam int FL_PATTERN_LO_BIT = 2;           // Patterns one..three at 2..4
    localparam int PATTERN_COUNT     = 3;
    localparam logic [4:0] FL_RESET  = 5'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;       // Answer for other addresses

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 25_000_000;  // Core clock, 40 ns
    localparam int AUTO_CLEAR_MS     = 8;           // Low time of the pin that starts the auto release
    localparam int AUTO_CLEAR_CYCLES = (CLK_HZ / 1000) * AUTO_CLEAR_MS;
    localparam int TIMER_WIDTH       = 18;          // Holds 200000

endpackage : ldi_pkg

`default_nettype wire

// ---- verilog/ldi_low_timer.sv ----
// Low-time timer for the interrupt pin.
// Assumes i_run is a registered level in the same clock domain.
`default_nettype none

module ldi_low_timer #(
    parameter int WIDTH = 18,                       // Counter width
    parameter int LIMIT = 200000                    // Cycles before expiry
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_run,                        // Pin held low and auto-clear on
    output var  logic o_expired                     // One-cycle pulse
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] count_reg;                    // Cycles spent low so far
    logic [WIDTH-1:0] count_next;

    // Restart whenever the pin leaves the low state or expiry fired,
    // so a fresh interrupt gets a full window again
    always_comb begin
        if (!i_run || o_expired) begin
            count_next = '0;
        end else begin
            count_next = count_reg + WIDTH'(1);
        end
    end

    // Count register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Expiry pulse once the low time has exceeded the limit
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_expired <= 1'b0;
        end else begin
            o_expired <= i_run && !o_expired && (count_reg == WIDTH'(LIMIT));
        end
    end

endmodule : ldi_low_timer

`default_nettype wire

// ---- verilog/ldi_irq_unit.sv ----
// Interrupt enable and flag logic of the LED matrix driver.
// Assumes the serial slave gives one-cycle read and write strobes with a
// byte address, and event sources give one-cycle pulses, all on i_clk.
// Event inputs are taken as levels; a held input keeps its flag set.
`default_nettype none

// Notes on behaviour
// - Enable bits 7..4 unused, all reset zero
// - Auto-clear releases pin after 8 ms low
// - Breath completion interrupts only when enabled
// - Short interrupts only when short enabled
// - Open interrupts only when open enabled
// - Read-only flags, patterns 4..2, short, open
// - One finish flag per breathing pattern
// - Finish flag reads one once finished
// - Short flag reads one after any short
// - Open flag reads one after open detected
module ldi_irq_unit
    import ldi_pkg::*;
#(
    parameter int AUTO_CLEAR_LIMIT = AUTO_CLEAR_CYCLES  // Shorten for simulation
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic [7:0] i_addr,                 // Register address
    input  wire logic       i_wr_en,                // Write strobe
    input  wire logic [7:0] i_wr_data,              // Write byte
    input  wire logic       i_rd_en,                // Read strobe
    input  wire logic [2:0] i_pattern_done,         // Breath loop finished, per pattern
    input  wire logic       i_short_event,          // Short detected on a dot
    input  wire logic       i_open_event,           // Open detected on a dot
    output var  logic [7:0] o_rd_data,              // Read byte, valid after strobe
    output var  logic [3:0] o_enables,              // Enable bits for the core
    output var  logic       o_irq_pin_n             // Interrupt pin, active low
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [3:0] enables_reg;                        // Interrupt enables
    logic [4:0] flags_reg;                          // Sticky flags
    logic [4:0] flags_next;
    logic [4:0] flag_set;                           // Events this cycle
    logic [4:0] flag_mask;                          // Enables spread to flags
    logic       flag_clear;                         // Read or auto release
    logic       irq_active;                         // Any enabled flag set
    logic       irq_pin_reg;
    logic [7:0] rd_data_reg;
    logic       timer_run;
    logic       timer_expired;
    logic       enables_write;                      // Write strobe aimed at the enables
    logic       flags_read;                         // Read strobe aimed at the flags

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Strobe qualified by one register address; every access arrives as
    // a single-cycle strobe, so no hold-off is needed here
    function automatic logic strobe_hits(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return strobe && (addr == target);
    endfunction

    // Decoded once and shared by the register, clear and read paths
    assign enables_write = strobe_hits(i_wr_en, i_addr, ADDR_ENABLES);
    assign flags_read    = strobe_hits(i_rd_en, i_addr, ADDR_FLAGS);

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------

    // Only the four low bits are kept; upper write bits are dropped
    // unused bits dropped, zero reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            enables_reg <= EN_RESET;
        end else if (enables_write) begin
            enables_reg <= i_wr_data[EN_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------

    // Flags record events whatever the enables; the source enables only gate the
    // pin, so a polling host still sees masked events
    // one flag per pattern
    assign flag_set = {i_pattern_done, i_short_event, i_open_event};

    // Reading the flags acknowledges them; auto release also drops them,
    // otherwise the pin would fall again on the very next cycle.
    // Limitation: an auto release also loses events the host never read
    assign flag_clear = flags_read || timer_expired;

    always_comb begin
        flags_next = flags_reg;
        if (flag_clear) begin
            flags_next = FL_RESET;
        end
        flags_next = flags_next | flag_set;
    end

    // Flag register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            flags_reg <= FL_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------

    assign flag_mask = {{PATTERN_COUNT{enables_reg[EN_BREATH_BIT]}},
                        enables_reg[EN_SHORT_BIT], enables_reg[EN_OPEN_BIT]};

    assign irq_active = |(flags_reg & flag_mask);

    // Registering the pin costs a cycle of latency but keeps decode
    // glitches off the pad
    // Pin register, released high out of reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            irq_pin_reg <= 1'b1;
        end else begin
            irq_pin_reg <= !irq_active;
        end
    end

    // time the pin only with auto-clear on
    assign timer_run = !irq_pin_reg && enables_reg[EN_AUTO_CLEAR_BIT];

    // Held at zero while auto-clear is off, so enabling it gives a full window
    // Low-time counter for the auto release
    ldi_low_timer #(
        .WIDTH (TIMER_WIDTH),
        .LIMIT (AUTO_CLEAR_LIMIT)
    ) u_low_timer (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_run     (timer_run),
        .o_expired (timer_expired)
    );

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------

    // Read byte holds until the next strobe, so the slave may shift it out late
    // flags in low bits, upper zero
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rd_data_reg <= READ_IDLE;
        end else if (i_rd_en) begin
            // The enable register is write only and reads as zero
            rd_data_reg <= flags_read ? {3'h0, flags_reg} : READ_IDLE;
        end
    end

    assign o_rd_data   = rd_data_reg;
    assign o_enables   = enables_reg;
    assign o_irq_pin_n = irq_pin_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    enable_reset_a: assert property ($rose(i_resetn) |-> enables_reg == 4'h0)
        else $error("enables not zero after reset");
    auto_release_a: assert property (!enables_reg[EN_AUTO_CLEAR_BIT] |=> !timer_expired)
        else $error("auto release without enable");
    breath_gate_a: assert property ((enables_reg == 4'h4 && flags_reg[4:2] == 3'h0) |=> o_irq_pin_n)
        else $error("pin low with no breath flag");
    short_gate_a: assert property ((enables_reg[2:0] == 3'h2 && !flags_reg[1]) |=> o_irq_pin_n)
        else $error("pin low with no short flag");
    open_gate_a: assert property ((enables_reg[2:0] == 3'h1 && !flags_reg[0]) |=> o_irq_pin_n)
        else $error("pin low with no open flag");
    flag_read_a: assert property ((i_rd_en && i_addr == ADDR_FLAGS) |=> o_rd_data == {3'h0, $past(flags_reg)})
        else $error("flag read data wrong");
    pattern_set_a: assert property (i_pattern_done[1] |=> flags_reg[3])
        else $error("pattern two flag missed");
    finish_hold_a: assert property ((flags_reg[4] && !flag_clear) |=> flags_reg[4])
        else $error("finish flag dropped");
    short_set_a: assert property (i_short_event |=> flags_reg[1] ##1 !o_irq_pin_n || !enables_reg[1])
        else $error("short flag missed");
    open_set_a: assert property ((i_open_event && !flag_clear) |=> flags_reg[0])
        else $error("open flag missed");
    pin_follow_a: assert property (irq_active |=> !o_irq_pin_n)
        else $error("pin not low on enabled flag");

    // Register holding, read decode, release and per-pattern capture
    enables_hold_a: assert property (!enables_write |=> $stable(enables_reg))
        else $error("enables changed without a write");
    other_read_a: assert property ((i_rd_en && !flags_read) |=> o_rd_data == READ_IDLE)
        else $error("read of other address not zero");
    expiry_clear_a: assert property (timer_expired |=> flags_reg == $past(flag_set))
        else $error("flags kept after auto release");
    pattern_one_a: assert property (i_pattern_done[0] |=> flags_reg[2])
        else $error("pattern one flag missed");
    pattern_three_a: assert property (i_pattern_done[2] |=> flags_reg[4])
        else $error("pattern three flag missed");
    pin_release_a: assert property (!irq_active |=> o_irq_pin_n)
        else $error("pin low with no enabled flag");

endmodule : ldi_irq_unit

`default_nettype wire

// ---- verif/ldi_host_model.sv ----
// Host microcontroller model: watches the interrupt pin and times its low periods.
// Assumes the pin is a registered level on the core clock and is never driven by the host.
`default_nettype none

module ldi_host_model (
    input  wire logic i_clk,
    input  wire logic i_irq_pin_n,   // Interrupt pin, active low
    output var  int   o_low_span     // Length of the last finished low period, cycles
);
    timeunit 1ns;
    timeprecision 1ps;

    int run_reg  = 0;                // Cycles seen low so far
    int span_reg = 0;                // Last finished low period

    // Count edges with the pin low; report once the pin is released
    always @(posedge i_clk) begin
        if (i_irq_pin_n === 1'b0) begin
            run_reg <= run_reg + 1;
        end else begin
            if (run_reg != 0) begin
                span_reg <= run_reg;
            end
            run_reg <= 0;
        end
    end

    assign o_low_span = span_reg;
endmodule // ldi_host_model

`default_nettype wire

// ---- verif/tb_ldi_irq_unit.sv ----
// Self-checking bench for the interrupt unit: byte strobe accesses and event pulses.
// Assumes the package constants and a shortened auto-clear limit.
`default_nettype none

module tb_ldi_irq_unit import ldi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 20;       // Short auto-clear count keeps the run brief
    logic       i_clk, i_resetn, i_wr_en, i_rd_en, i_short_event, i_open_event;
    logic [7:0] i_addr, i_wr_data, o_rd_data, d;
    logic [2:0] i_pattern_done;
    logic [3:0] o_enables;
    logic       o_irq_pin_n;
    int         low_span, bad_count, checks_done, e_want;

    ldi_irq_unit #(.AUTO_CLEAR_LIMIT(LIMIT)) ldi_irq_unit_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
        .i_pattern_done(i_pattern_done), .i_short_event(i_short_event), .i_open_event(i_open_event),
        .o_rd_data(o_rd_data), .o_enables(o_enables), .o_irq_pin_n(o_irq_pin_n));
    ldi_host_model ldi_host_model_i (.i_clk(i_clk), .i_irq_pin_n(o_irq_pin_n), .o_low_span(low_span));

    always #20 i_clk = ~i_clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // One-cycle write strobe; returns once the sampling edge has passed
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk); i_addr <= a; i_wr_data <= v; i_wr_en <= 1'b1;
        @(posedge i_clk); i_wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk); i_addr <= a; i_rd_en <= 1'b1;
        @(posedge i_clk); i_rd_en <= 1'b0;
        #1 v = o_rd_data;
    endtask
    // Event pulse: bits 4..2 patterns, bit 1 short, bit 0 open
    task automatic ev(input logic [4:0] m);
        @(posedge i_clk); i_pattern_done <= m[4:2]; i_short_event <= m[1]; i_open_event <= m[0];
        @(posedge i_clk); i_pattern_done <= 3'h0; i_short_event <= 1'b0; i_open_event <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {i_clk, i_resetn, i_wr_en, i_rd_en, i_short_event, i_open_event} = 6'h00;
        {i_addr, i_wr_data, i_pattern_done} = 19'h00000;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        tick(1);
        chk("enables", 8'h00, {4'h0, o_enables});
        chk("pin", 8'h01, {7'h00, o_irq_pin_n});
        rd(ADDR_FLAGS, d); chk("flags", 8'h00, d);
        $display("test reset done");
        // All sources off: flags set, pin stays released
        ev(5'h1f); tick(3); chk("pin", 8'h01, {7'h00, o_irq_pin_n});
        rd(ADDR_FLAGS, d); chk("flags", 8'h1f, d);
        rd(ADDR_FLAGS, d); chk("flags", 8'h00, d);
        rd(ADDR_ENABLES, d); chk("enables read", 8'h00, d);
        $display("test masked events done");
        // Every source against each source enable bit (0..2), unused bits written high
        for (int k = 0; k < 5; k++) begin
            for (int e = 0; e < 3; e++) begin
                e_want = (k > 1) ? 2 : k;
                wr(ADDR_ENABLES, 8'hf0 | (8'h01 << e)); chk("enables", 8'h01 << e, {4'h0, o_enables});
                ev(5'h01 << k); tick(3); chk("pin", (e == e_want) ? 8'h00 : 8'h01, {7'h00, o_irq_pin_n});
                rd(ADDR_FLAGS, d); chk("flags", 8'h01 << k, d);
                tick(3); chk("pin", 8'h01, {7'h00, o_irq_pin_n});
            end
        end
        $display("test source matrix done");
        // Pending flag drives the pin once its enable is set later
        wr(ADDR_ENABLES, 8'h00); ev(5'h02); tick(3);
        wr(ADDR_ENABLES, 8'h02); tick(3); chk("pin", 8'h00, {7'h00, o_irq_pin_n});
        wr(8'h12, 8'h0f); chk("enables", 8'h02, {4'h0, o_enables});
        // Without auto-clear the pin outlasts the limit
        tick(3 * LIMIT); chk("pin", 8'h00, {7'h00, o_irq_pin_n});
        rd(ADDR_FLAGS, d); tick(3);
        $display("test late enable done");
        // Auto-clear releases the pin after the limit
        wr(ADDR_ENABLES, 8'h0a); ev(5'h02);
        // The pin is still high when the event task returns: see it fall first
        for (int n = 0; n < 4 && o_irq_pin_n !== 1'b0; n++) tick(1);
        chk("pin", 8'h00, {7'h00, o_irq_pin_n});
        for (int n = 0; n < LIMIT + 20 && o_irq_pin_n !== 1'b1; n++) tick(1);
        chk("pin", 8'h01, {7'h00, o_irq_pin_n});
        tick(1); chk("low span", 8'(LIMIT + 3), 8'(low_span));
        rd(ADDR_FLAGS, d); chk("flags", 8'h00, d);
        $display("test auto clear done");
        give_verdict();
    end

    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(40 * 5000);
        bad_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        give_verdict();
    end
endmodule // tb_ldi_irq_unit

`default_nettype wire
